//--- logic/mmdira_pkg.sv
// Constants and types for the indirect extended-register access block.
// Assumes a single system clock; management pins are sampled, not clocked.
package mmdira_pkg;

  // ==========================================================================
  // Register map
  localparam logic [4:0]  REG_ACCESS_CONTROL = 5'h0d;
  localparam logic [4:0]  REG_ADDR_DATA_WIN  = 5'h0e;
  localparam int          STD_REGS           = 32;
  localparam logic [15:0] EXT_BASE           = 16'h0020;
  localparam logic [15:0] ACR_RESET          = 16'h0000;
  localparam logic [15:0] PTR_RESET          = 16'h0000;
  localparam logic [15:0] STD_RESET          = 16'h0000;

  // ==========================================================================
  // Access-control fields
  localparam int          FUNC_HI            = 15;
  localparam int          FUNC_LO            = 14;
  localparam int          DEV_HI             = 4;
  localparam int          DEV_LO             = 0;
  localparam logic [4:0]  DEV_HONOURED       = 5'h1f;

  typedef enum logic [1:0] {
    MMDIRA_FN_ADDR   = 2'b00,
    MMDIRA_FN_DATA   = 2'b01,
    MMDIRA_FN_INC_RW = 2'b10,
    MMDIRA_FN_INC_W  = 2'b11
  } mmdira_func_t;

  // ==========================================================================
  // Management frame
  localparam logic [1:0]  OP_READ            = 2'b10;
  localparam logic [1:0]  OP_WRITE           = 2'b01;
  localparam logic [4:0]  HDR_LAST           = 5'h0b;
  localparam logic [4:0]  TA_LAST            = 5'h01;
  localparam logic [4:0]  DATA_LAST          = 5'h0f;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regn;
  } mmdira_hdr_t;

  typedef enum logic [2:0] {
    MMDIRA_IDLE  = 3'b000,
    MMDIRA_START = 3'b001,
    MMDIRA_HDR   = 3'b010,
    MMDIRA_TA    = 3'b011,
    MMDIRA_DATA  = 3'b100
  } mmdira_state_t;

endpackage

//--- logic/mmdira_top.sv
// Management serial slave with indirect window onto an extended register set.
// Assumes mdc and mdio_in come from another domain; mdc runs far below sys_clk.
`timescale 1ns/1ps
module mmdira_top #(
  parameter int EXT_WORDS = 64
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Station address strap, caught during reset
  input  wire logic [4:0] phy_addr,
  // Management serial pins
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe
);

  localparam int EXT_AW = (EXT_WORDS > 1) ? $clog2(EXT_WORDS) : 1;
  localparam logic [16:0] EXT_END = 17'(EXT_WORDS) + {1'b0, mmdira_pkg::EXT_BASE};

  // ==========================================================================
  // Synchronisers and edge detect
  logic       mdc_s1_reg, mdc_s2_reg, mdc_s3_reg;
  logic       mdio_s1_reg, mdio_s2_reg;
  logic [4:0] phy_s1_reg, phy_s2_reg;
  wire  logic mdc_rise = mdc_s2_reg & ~mdc_s3_reg;
  wire  logic bit_in   = mdio_s2_reg;

  always_ff @(posedge sys_clk) begin
    mdc_s1_reg  <= mdc;
    mdc_s2_reg  <= mdc_s1_reg;
    mdc_s3_reg  <= mdc_s2_reg;
    mdio_s1_reg <= mdio_in;
    mdio_s2_reg <= mdio_s1_reg;
    phy_s1_reg  <= phy_addr;
    phy_s2_reg  <= phy_s1_reg;
  end

  // ==========================================================================
  // Register storage
  logic [15:0] acr_reg;
  logic [15:0] ptr_reg;
  logic [15:0] std_mem [mmdira_pkg::STD_REGS];
  logic [15:0] ext_mem [EXT_WORDS];
  logic [4:0]  phyad_reg;

  // Classifies a pointer: 0 none, 1 standard, 2 extended
  function automatic logic [1:0] tgt_kind(input logic [15:0] p);
    if (p < 16'(mmdira_pkg::STD_REGS))
      tgt_kind = (p[4:0] == mmdira_pkg::REG_ACCESS_CONTROL ||
                  p[4:0] == mmdira_pkg::REG_ADDR_DATA_WIN) ? 2'h0 : 2'h1;
    else if ({1'b0, p} < EXT_END)
      tgt_kind = 2'h2;
    else
      tgt_kind = 2'h0;
  endfunction

  wire logic [1:0]        func    = acr_reg[mmdira_pkg::FUNC_HI:
                                            mmdira_pkg::FUNC_LO];
  wire logic              win_on  = acr_reg[mmdira_pkg::DEV_HI:mmdira_pkg::DEV_LO]
                                    == mmdira_pkg::DEV_HONOURED;
  wire logic [1:0]        kind    = tgt_kind(ptr_reg);
  wire logic [EXT_AW-1:0] ext_idx = EXT_AW'(ptr_reg - mmdira_pkg::EXT_BASE);
  wire logic              fn_addr = func == mmdira_pkg::MMDIRA_FN_ADDR;

  // ==========================================================================
  // Frame engine
  mmdira_pkg::mmdira_state_t state_reg;
  logic [4:0]  cnt_reg;
  logic [11:0] hdr_reg;
  logic [15:0] sh_reg;
  logic        ours_reg, isrd_reg;

  wire mmdira_pkg::mmdira_hdr_t hdr_now = mmdira_pkg::mmdira_hdr_t'({hdr_reg[10:0], bit_in});
  wire mmdira_pkg::mmdira_hdr_t hdr     = mmdira_pkg::mmdira_hdr_t'(hdr_reg);

  // Window read value and direct read mux
  wire logic [15:0] win_data = (kind == 2'h1) ? std_mem[ptr_reg[4:0]] :
                               (kind == 2'h2) ? ext_mem[ext_idx] : 16'h0000;
  wire logic [15:0] win_val  = !win_on ? 16'h0000 :
                               fn_addr ? ptr_reg : win_data;
  wire logic [15:0] rd_val   = (hdr.regn == mmdira_pkg::REG_ACCESS_CONTROL) ?
                               acr_reg :
                               (hdr.regn == mmdira_pkg::REG_ADDR_DATA_WIN)  ? win_val :
                               std_mem[hdr.regn];

  wire logic        last    = (state_reg == mmdira_pkg::MMDIRA_DATA) && mdc_rise &&
                              (cnt_reg == mmdira_pkg::DATA_LAST);
  wire logic [15:0] wdata   = {sh_reg[14:0], bit_in};
  wire logic        wr_evt  = last & ours_reg & ~isrd_reg;
  wire logic        rd_evt  = last & ours_reg & isrd_reg;
  wire logic        is_acr  = hdr.regn == mmdira_pkg::REG_ACCESS_CONTROL;
  wire logic        is_win  = hdr.regn == mmdira_pkg::REG_ADDR_DATA_WIN;
  wire logic        win_wr  = wr_evt & is_win & win_on;
  wire logic        win_rd  = rd_evt & is_win & win_on;
  wire logic        std_wr  = wr_evt & ~is_acr & ~is_win;
  wire logic        data_wr = win_wr & ~fn_addr;
  wire logic        ptr_inc = (win_wr & func[1]) |
                              (win_rd & (func == mmdira_pkg::MMDIRA_FN_INC_RW));
  wire logic [15:0] ptr_next = (win_wr & fn_addr) ? wdata :
                               ptr_inc ? ptr_reg + 16'h0001 : ptr_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= mmdira_pkg::MMDIRA_IDLE;
      cnt_reg   <= 5'h00;
      hdr_reg   <= 12'h000;
      sh_reg    <= 16'h0000;
      ours_reg  <= 1'b0;
      isrd_reg  <= 1'b0;
      mdio_oe   <= 1'b0;
      mdio_out  <= 1'b0;
    end else if (mdc_rise) begin
      case (state_reg)
        mmdira_pkg::MMDIRA_IDLE: begin
          if (!bit_in)
            state_reg <= mmdira_pkg::MMDIRA_START;
        end
        mmdira_pkg::MMDIRA_START: begin
          state_reg <= bit_in ? mmdira_pkg::MMDIRA_HDR : mmdira_pkg::MMDIRA_START;
          cnt_reg   <= 5'h00;
        end
        mmdira_pkg::MMDIRA_HDR: begin
          hdr_reg <= {hdr_reg[10:0], bit_in};
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == mmdira_pkg::HDR_LAST) begin
            state_reg <= mmdira_pkg::MMDIRA_TA;
            cnt_reg   <= 5'h00;
            ours_reg  <= (hdr_now.phy == phyad_reg) &&
                         (hdr_now.op == mmdira_pkg::OP_READ || hdr_now.op == mmdira_pkg::OP_WRITE);
            isrd_reg  <= hdr_now.op == mmdira_pkg::OP_READ;
          end
        end
        mmdira_pkg::MMDIRA_TA: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg != mmdira_pkg::TA_LAST) begin
            mdio_oe  <= ours_reg & isrd_reg;
            mdio_out <= 1'b0;
          end else begin
            state_reg <= mmdira_pkg::MMDIRA_DATA;
            cnt_reg   <= 5'h00;
            mdio_out  <= rd_val[15];
            sh_reg    <= {rd_val[14:0], 1'b0};
          end
        end
        mmdira_pkg::MMDIRA_DATA: begin
          cnt_reg  <= cnt_reg + 5'h01;
          mdio_out <= sh_reg[15];
          sh_reg   <= isrd_reg ? {sh_reg[14:0], 1'b0} : wdata;
          if (cnt_reg == mmdira_pkg::DATA_LAST) begin
            state_reg <= mmdira_pkg::MMDIRA_IDLE;
            mdio_oe   <= 1'b0;
            mdio_out  <= 1'b0;
          end
        end
        default: state_reg <= mmdira_pkg::MMDIRA_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Register updates
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phyad_reg <= phy_s2_reg;
      acr_reg   <= mmdira_pkg::ACR_RESET;
      ptr_reg   <= mmdira_pkg::PTR_RESET;
    end else begin
      ptr_reg <= ptr_next;
      if (wr_evt && is_acr)
        acr_reg <= wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < mmdira_pkg::STD_REGS; i++)
        std_mem[i] <= mmdira_pkg::STD_RESET;
      for (int j = 0; j < EXT_WORDS; j++)
        ext_mem[j] <= mmdira_pkg::STD_RESET;
    end else begin
      if (std_wr)
        std_mem[hdr.regn] <= wdata;
      if (data_wr && kind == 2'h1)
        std_mem[ptr_reg[4:0]] <= wdata;
      if (data_wr && kind == 2'h2)
        ext_mem[ext_idx] <= wdata;
    end
  end

  // ==========================================================================
  // Checks
  reset_clear_a: assert property (@(posedge sys_clk)
    srst |=> (acr_reg == 16'h0000 && ptr_reg == 16'h0000))
    else $error("control or pointer not cleared by reset");

  acr_store_a: assert property (@(posedge sys_clk) disable iff (srst)
    (wr_evt && is_acr) |=> acr_reg == $past(wdata))
    else $error("control register lost a write");

  addr_load_a: assert property (@(posedge sys_clk) disable iff (srst)
    (win_wr && fn_addr) |=> ptr_reg == $past(wdata))
    else $error("pointer not loaded in address function");

  inc_rw_a: assert property (@(posedge sys_clk) disable iff (srst)
    ((win_wr || win_rd) && func == 2'b10) |=> ptr_reg == $past(ptr_reg) + 16'h0001)
    else $error("pointer did not increment");

  inc_wonly_a: assert property (@(posedge sys_clk) disable iff (srst)
    (win_rd && func == 2'b11) |=> $stable(ptr_reg))
    else $error("pointer moved on read in write-increment mode");

  no_inc_a: assert property (@(posedge sys_clk) disable iff (srst)
    ((win_wr || win_rd) && func == 2'b01) |=> $stable(ptr_reg))
    else $error("pointer moved in no-increment mode");

  dev_ignore_a: assert property (@(posedge sys_clk) disable iff (srst)
    (last && !win_on && !(wr_evt && is_acr)) |=> $stable(ptr_reg) && $stable(acr_reg))
    else $error("window access with wrong device had effect");

  self_ignore_a: assert property (@(posedge sys_clk) disable iff (srst)
    (data_wr && (ptr_reg == 16'h000d || ptr_reg == 16'h000e)) |=>
      ($stable(acr_reg) && $stable(std_mem[13]) && $stable(std_mem[14])))
    else $error("indirect write reached control register");

  ta_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(mdio_oe) |-> !mdio_out ##1 (mdio_oe && !mdio_out))
    else $error("turnaround bit not driven low");

endmodule // mmdira_top

//--- sim/mmdira_sta.sv
// Station model that frames reads and writes on the management serial pins.
// Assumes sys_clk runs at least 8x mdc; the shared line has a pull-up.
`timescale 1ns/1ps
module mmdira_sta (
  // Clock
  input  wire logic sys_clk,
  // Device side of the line
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  // Station side
  output logic      mdc,
  output wire logic mdio_wire
);
  logic        drv;
  logic        lvl;
  logic [15:0] sh;
  int          half = 4;

  // Released line floats high
  assign mdio_wire = drv ? lvl : (mdio_oe ? mdio_out : 1'b1);

  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    lvl = 1'b1;
  end

  // ==========================================================================
  // One frame; mdc stands low between frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regn,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] fr;
    fr = {2'b01, op, phy, regn, 2'b10, wd};
    for (int i = 31; i >= 0; i--) begin
      mdc <= 1'b0;
      drv <= (op == mmdira_pkg::OP_WRITE) || (i > 17);
      lvl <= fr[i];
      repeat (half - 1) @(posedge sys_clk);
      @(negedge sys_clk) sh = {sh[14:0], mdio_wire};
      @(posedge sys_clk) mdc <= 1'b1;
      repeat (half) @(posedge sys_clk);
    end
    mdc <= 1'b0;
    drv <= 1'b0;
    rd = sh;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule // mmdira_sta

//--- sim/tb.sv
// Self-checking bench for the indirect extended-register window.
// Assumes the station model owns the serial pins; the strap address is fixed.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  localparam logic [4:0] STRAP = 5'h05;
  localparam int         LIMIT = 40000;
  logic        sys_clk;
  logic        srst;
  logic [4:0]  phy_addr;
  logic        mdc;
  wire         mdio_wire;
  logic        mdio_out;
  logic        mdio_oe;
  logic [15:0] d;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  mmdira_top #(.EXT_WORDS(4)) u_dut (.sys_clk(sys_clk), .srst(srst), .phy_addr(phy_addr),
    .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  mmdira_sta u_sta (.sys_clk(sys_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_wire(mdio_wire));

  always #20 sys_clk = ~sys_clk;

  // ==========================================================================
  // Access helpers
  task automatic wr(input logic [4:0] r, input logic [15:0] v);
    u_sta.xfer(mmdira_pkg::OP_WRITE, STRAP, r, v, d);
  endtask
  task automatic rchk(input logic [4:0] r, input logic [15:0] exp);
    u_sta.xfer(mmdira_pkg::OP_READ, STRAP, r, 16'h0000, d);
    `CHK(d, exp)
  endtask
  task automatic ptr(input logic [15:0] a, input logic [15:0] fn);
    wr(5'h0d, 16'h001f);
    wr(5'h0e, a);
    wr(5'h0d, fn);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rchk(5'h0d, mmdira_pkg::ACR_RESET);
    rchk(5'h0e, mmdira_pkg::PTR_RESET);
    wr(5'h0d, 16'h3fe5);
    rchk(5'h0d, 16'h3fe5);
  endtask
  task automatic t_addr();
    wr(5'h0d, 16'h001f);
    wr(5'h0e, 16'h0021);
    wr(5'h0e, 16'h0022);
    wr(5'h0f, 16'h0055);
    rchk(5'h0e, 16'h0022);
    rchk(5'h0e, 16'h0022);
    rchk(5'h0f, 16'h0055);
  endtask
  task automatic t_nopi();
    ptr(16'h0022, 16'h401f);
    wr(5'h0e, 16'ha5a5);
    rchk(5'h0e, 16'ha5a5);
    rchk(5'h0e, 16'ha5a5);
    wr(5'h0d, 16'h001f);
    rchk(5'h0e, 16'h0022);
    wr(5'h0d, 16'h401f);
    rchk(5'h0e, 16'ha5a5);
  endtask
  task automatic t_inc();
    ptr(16'h0020, 16'hc01f);
    wr(5'h0e, 16'h1111);
    wr(5'h0e, 16'h2222);
    wr(5'h0e, 16'h3333);
    rchk(5'h0e, 16'h0000);
    wr(5'h0d, 16'h001f);
    rchk(5'h0e, 16'h0023);
    u_sta.half = 7;
    ptr(16'h0020, 16'h801f);
    rchk(5'h0e, 16'h1111);
    rchk(5'h0e, 16'h2222);
    rchk(5'h0e, 16'h3333);
    u_sta.half = 4;
    wr(5'h0e, 16'h4444);
    wr(5'h0d, 16'h001f);
    rchk(5'h0e, 16'h0024);
    wr(5'h0d, 16'h3fff);
    rchk(5'h0e, 16'h0024);
    ptr(16'h0023, 16'h401f);
    rchk(5'h0e, 16'h4444);
  endtask
  task automatic t_std();
    ptr(16'h0003, 16'h401f);
    wr(5'h0e, 16'h1234);
    rchk(5'h03, 16'h1234);
    wr(5'h03, 16'h5678);
    rchk(5'h0e, 16'h5678);
    ptr(16'h000d, 16'h401f);
    wr(5'h0e, 16'h0000);
    rchk(5'h0d, 16'h401f);
    rchk(5'h0e, 16'h0000);
  endtask
  task automatic t_dev();
    wr(5'h0d, 16'h401e);
    wr(5'h0e, 16'hbeef);
    rchk(5'h0e, 16'h0000);
    wr(5'h0d, 16'h001e);
    wr(5'h0e, 16'h0007);
    wr(5'h0d, 16'h001f);
    rchk(5'h0e, 16'h000d);
    u_sta.xfer(mmdira_pkg::OP_WRITE, STRAP ^ 5'h01, 5'h0d, 16'h0000, d);
    rchk(5'h0d, 16'h001f);
    ptr(16'hffff, 16'h801f);
    rchk(5'h0e, 16'h0000);
    wr(5'h0d, 16'h001f);
    rchk(5'h0e, 16'h0000);
  endtask

  // ==========================================================================
  // Verdict and hang guard
  task automatic conclude();
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      conclude();
    end
  end

  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    phy_addr = STRAP;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_addr();
    t_nopi();
    t_inc();
    t_std();
    t_dev();
    conclude();
  end
endmodule // tb
